/* File: verilog/ttc_map.svh */
// register offsets, control bit positions and other constants of the triple timer
// Summary of operation
// - three independent 16-bit timers; 0/1 own pins
// - one counter element time-shared over three banks
// - registers accessible while running, no torn reads
// - one wait state on every register access
// - counter servicing continues during locked accesses
// - events: pin edge, quarter clock, timer 2
// - counts undefined at reset; software clears first
// - count equal to limit resets to zero
// - limit zero means 65536 events period
// - equality compare only; overshoot wraps through 0FFFFH
// - no flag or interrupt on plain wrap
// - dual mode alternates limit A then B
// - dual select low uses only limit A
// - limit in use bit, read only, 0 single
// - interrupt request when active limit reached with interrupt enable set
// - limit reached flag sticky, software clears
// - repeated request overwrites unserviced earlier one
// - one request line, per-timer vector, fixed priority
// - count advances only while enable set
// - enable written only with write gate set
// - no auto repeat clears enable at cycle end
// - timers 0/1 gated by input pin
// - prescale select picks timer 2 timeout
// - level gating holds count, pin retrigger clears it
`ifndef TTC_MAP_SVH
`define TTC_MAP_SVH

`define TTC_OFS_T0_COUNT 8'h30
`define TTC_OFS_T0_LIMIT_A 8'h32
`define TTC_OFS_T0_LIMIT_B 8'h34
`define TTC_OFS_T0_CONTROL 8'h36
`define TTC_OFS_T1_COUNT 8'h38
`define TTC_OFS_T1_LIMIT_A 8'h3A
`define TTC_OFS_T1_LIMIT_B 8'h3C
`define TTC_OFS_T1_CONTROL 8'h3E
`define TTC_OFS_T2_COUNT 8'h40
`define TTC_OFS_T2_LIMIT_A 8'h42
`define TTC_OFS_RESERVED 8'h44
`define TTC_OFS_T2_CONTROL 8'h46
`define TTC_OFS_LAST 8'h47

`define TTC_FLD_COUNT 2'h0
`define TTC_FLD_LIMIT_A 2'h1
`define TTC_FLD_LIMIT_B 2'h2
`define TTC_FLD_CONTROL 2'h3

`define TTC_BIT_EN 15
`define TTC_BIT_GATE 14
`define TTC_BIT_IEN 13
`define TTC_BIT_RIU 12
`define TTC_BIT_MC 5
`define TTC_BIT_RTG 4
`define TTC_BIT_PRE 3
`define TTC_BIT_EXT 2
`define TTC_BIT_ALT 1
`define TTC_BIT_AUTO_REPEAT 0

`define TTC_NUM_TIMERS 3
`define TTC_CNT_STEP 16'h0001
`define TTC_OUT_IDLE 1'b1

`endif

/* File: verilog/ttc_pkg.sv */
// types shared by the triple timer
package ttc_pkg;

  typedef logic [15:0] ttc_word_t;

  // counter element slots; the fourth slot gives the quarter-clock rate
  typedef enum logic [1:0] {SLOT_T0, SLOT_T1, SLOT_T2, SLOT_SPARE} ttc_slot_e;

endpackage : ttc_pkg

/* File: verilog/ttc_top.sv */
// triple timer: shared counter element, three banks, waited register port
`timescale 1ns/1ps
`include "ttc_map.svh"

module ttc_top
  import ttc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_sel,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ready,
  // timer pins
  input wire logic timer_in0,
  input wire logic timer_in1,
  output logic timer_out0,
  output logic timer_out1,
  // interrupt request
  output logic timer_irq,
  output logic [1:0] timer_irq_id,
  input wire logic timer_irq_ack
);

  ////////////////////////////////////////////////////////////////////////////
  // counter element sequencer

  ttc_slot_e slot;
  ttc_slot_e next_slot;
  wire [3:0] svc_vec;

  always_comb
  begin
    unique case (slot)
      SLOT_T0: next_slot = SLOT_T1;
      SLOT_T1: next_slot = SLOT_T2;
      SLOT_T2: next_slot = SLOT_SPARE;
      SLOT_SPARE: next_slot = SLOT_T0;
    endcase
  end

  // free running, never held by the register port
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      slot <= SLOT_T0;
    else
      slot <= next_slot;
  end

  assign svc_vec = 4'(4'h1 << slot);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and rising edge detect

  wire [2:0] pin_raw;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  wire [2:0] pin_rise;

  assign pin_raw = {1'b0, timer_in1, timer_in0};

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign pin_rise = pin_s2 & ~pin_s3;

  ////////////////////////////////////////////////////////////////////////////
  // register port: request taken, answer one cycle later

  logic wr_pend;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  wire take;
  wire [7:0] rd_rel;
  wire [7:0] wr_rel;
  wire rd_in;
  wire wr_in;
  wire [1:0] rd_tim;
  wire [1:0] rd_fld;
  wire [1:0] wr_tim;
  wire [1:0] wr_fld;
  wire rd_ok;
  wire wr_ok;
  logic [15:0] rd_word;

  assign take = reg_sel & (reg_rd | reg_wr) & ~reg_ready;

  assign rd_rel = 8'(reg_addr - `TTC_OFS_T0_COUNT);
  assign wr_rel = 8'(wr_addr - `TTC_OFS_T0_COUNT);
  assign rd_in = (reg_addr >= `TTC_OFS_T0_COUNT) && (reg_addr <= `TTC_OFS_LAST) && !reg_addr[0];
  assign wr_in = (wr_addr >= `TTC_OFS_T0_COUNT) && (wr_addr <= `TTC_OFS_LAST) && !wr_addr[0];
  assign rd_tim = rd_rel[4:3];
  assign rd_fld = rd_rel[2:1];
  assign wr_tim = wr_rel[4:3];
  assign wr_fld = wr_rel[2:1];
  // timer 2 has no second limit: that slot is the reserved word
  assign rd_ok = rd_in && !(rd_tim == 2'h2 && rd_fld == `TTC_FLD_LIMIT_B);
  assign wr_ok = wr_pend && wr_in && !(wr_tim == 2'h2 && wr_fld == `TTC_FLD_LIMIT_B);

  // bank state as seen by the port
  wire [15:0] cnt_v [3];
  wire [15:0] lim_a_v [3];
  wire [15:0] lim_b_v [3];
  wire [15:0] ctl_v [3];
  wire [2:0] hit_v;
  wire [2:0] riu_v;
  wire [2:0] alt_v;
  wire t2_hit;

  always_comb
  begin
    rd_word = 16'h0000;
    if (rd_ok)
    begin
      unique case (rd_fld)
        `TTC_FLD_COUNT: rd_word = cnt_v[rd_tim];
        `TTC_FLD_LIMIT_A: rd_word = lim_a_v[rd_tim];
        `TTC_FLD_LIMIT_B: rd_word = lim_b_v[rd_tim];
        `TTC_FLD_CONTROL: rd_word = ctl_v[rd_tim];
      endcase
    end
  end

  // read data snapshots whole words; writes land in the answer cycle, while ready is high
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      reg_ready <= 1'b0;
      reg_rdata <= 16'h0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 16'h0000;
    end
    else
    begin
      reg_ready <= take;
      reg_rdata <= (take && reg_rd) ? rd_word : 16'h0000;
      wr_pend <= take & reg_wr;
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer banks, serviced one per slot

  for (genvar k = 0; k < `TTC_NUM_TIMERS; k++)
  begin : g_tim
    localparam bit FULL = (k != 2);

    logic [15:0] cnt_q;
    logic [15:0] lim_a_q;
    logic [15:0] lim_b_q;
    logic en_q;
    logic auto_repeat_q;
    logic alt_q;
    logic riu_q;
    logic mc_q;
    logic ext_q;
    logic pre_q;
    logic rtg_q;
    logic ien_q;
    logic armed_q;
    logic edge_q;
    logic t2_q;
    logic [15:0] ctl_q;

    wire svc;
    wire [15:0] lim_act;
    wire [15:0] cnt_inc;
    wire match;
    wire ev;
    wire ok;
    wire retrig;
    wire step;
    wire hit;
    wire cyc_end;
    wire wr_me;
    wire wr_cnt;
    wire wr_lim_a;
    wire wr_lim_b;
    wire wr_ctl;

    assign svc = svc_vec[k];
    assign lim_act = (FULL && alt_q && riu_q) ? lim_b_q : lim_a_q;
    assign cnt_inc = 16'(cnt_q + `TTC_CNT_STEP);
    // equality on the next value: limit 0 matches after 0FFFFH
    assign match = (cnt_inc == lim_act);
    assign ev = (FULL && ext_q) ? edge_q : ((FULL && pre_q) ? t2_q : 1'b1);
    assign ok = en_q
      && !(FULL && !ext_q && !rtg_q && !pin_s2[k])
      && !(FULL && !ext_q && rtg_q && !armed_q);
    assign retrig = FULL && !ext_q && rtg_q && edge_q && en_q;
    assign step = svc && ok && ev && !retrig;
    assign hit = step && match;
    assign cyc_end = !(FULL && alt_q) || riu_q;

    assign wr_me = wr_ok && (wr_tim == 2'(k));
    assign wr_cnt = wr_me && (wr_fld == `TTC_FLD_COUNT);
    assign wr_lim_a = wr_me && (wr_fld == `TTC_FLD_LIMIT_A);
    assign wr_lim_b = wr_me && (wr_fld == `TTC_FLD_LIMIT_B) && FULL;
    assign wr_ctl = wr_me && (wr_fld == `TTC_FLD_CONTROL);

    // count and limits carry no reset value
    always_ff @(posedge core_clk)
    begin
      if (svc && retrig)
        cnt_q <= 16'h0000;
      else if (step)
        cnt_q <= match ? 16'h0000 : cnt_inc;
      if (wr_cnt)
        cnt_q <= wr_data;
      if (wr_lim_a)
        lim_a_q <= wr_data;
      if (wr_lim_b)
        lim_b_q <= wr_data;
    end

    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        en_q <= 1'b0;
        auto_repeat_q <= 1'b0;
        alt_q <= 1'b0;
        riu_q <= 1'b0;
        mc_q <= 1'b0;
        ext_q <= 1'b0;
        pre_q <= 1'b0;
        rtg_q <= 1'b0;
        ien_q <= 1'b0;
        armed_q <= 1'b0;
        edge_q <= 1'b0;
        t2_q <= 1'b0;
      end
      else
      begin
        // latched pin edge and timer 2 timeout, consumed at service, set wins
        edge_q <= pin_rise[k] | (edge_q & ~svc);
        t2_q <= t2_hit | (t2_q & ~svc);
        if (!en_q)
          armed_q <= 1'b0;
        else if (svc && retrig)
          armed_q <= 1'b1;
        if (hit && FULL && alt_q)
          riu_q <= ~riu_q;
        if (hit && cyc_end && !auto_repeat_q)
          en_q <= 1'b0;
        if (wr_ctl)
        begin
          if (wr_data[`TTC_BIT_GATE])
            en_q <= wr_data[`TTC_BIT_EN];
          auto_repeat_q <= wr_data[`TTC_BIT_AUTO_REPEAT];
          ien_q <= wr_data[`TTC_BIT_IEN];
          mc_q <= wr_data[`TTC_BIT_MC];
          if (FULL)
          begin
            alt_q <= wr_data[`TTC_BIT_ALT];
            ext_q <= wr_data[`TTC_BIT_EXT];
            pre_q <= wr_data[`TTC_BIT_PRE];
            rtg_q <= wr_data[`TTC_BIT_RTG];
            if (!wr_data[`TTC_BIT_ALT])
              riu_q <= 1'b0;
          end
        end
        if (hit)
          mc_q <= 1'b1;
      end
    end

    // gate bit is never stored and reads zero
    always_comb
    begin
      ctl_q = 16'h0000;
      ctl_q[`TTC_BIT_EN] = en_q;
      ctl_q[`TTC_BIT_IEN] = ien_q;
      ctl_q[`TTC_BIT_RIU] = riu_q && alt_q;
      ctl_q[`TTC_BIT_MC] = mc_q;
      ctl_q[`TTC_BIT_RTG] = rtg_q;
      ctl_q[`TTC_BIT_PRE] = pre_q;
      ctl_q[`TTC_BIT_EXT] = ext_q;
      ctl_q[`TTC_BIT_ALT] = alt_q;
      ctl_q[`TTC_BIT_AUTO_REPEAT] = auto_repeat_q;
    end

    assign cnt_v[k] = cnt_q;
    assign lim_a_v[k] = lim_a_q;
    assign lim_b_v[k] = FULL ? lim_b_q : 16'h0000;
    assign ctl_v[k] = ctl_q;
    assign hit_v[k] = hit && ien_q;
    assign riu_v[k] = riu_q;
    assign alt_v[k] = alt_q;
  end

  assign t2_hit = g_tim[2].hit;

  ////////////////////////////////////////////////////////////////////////////
  // timer output pins

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      timer_out0 <= `TTC_OUT_IDLE;
      timer_out1 <= `TTC_OUT_IDLE;
    end
    else
    begin
      // dual: high on limit A, low on B; single: low one clock after a hit
      timer_out0 <= alt_v[0] ? ~riu_v[0] : ~g_tim[0].hit;
      timer_out1 <= alt_v[1] ? ~riu_v[1] : ~g_tim[1].hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt merge: timer 0 highest, timer 2 lowest

  logic [2:0] pend;
  wire [2:0] ack_vec;
  wire [2:0] next_pend;
  wire [1:0] next_id;

  assign ack_vec = timer_irq_ack ? 3'(3'h1 << timer_irq_id) : 3'h0;
  // a new hit re-sets the same bit, so an unserviced one is overwritten
  assign next_pend = hit_v | (pend & ~ack_vec);
  assign next_id = next_pend[0] ? 2'h0 : (next_pend[1] ? 2'h1 : 2'h2);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pend <= 3'h0;
      timer_irq <= 1'b0;
      timer_irq_id <= 2'h0;
    end
    else
    begin
      pend <= next_pend;
      timer_irq <= |next_pend;
      timer_irq_id <= next_id;
    end
  end

endmodule : ttc_top

/* File: verification/ttc_properties.sv */
// concurrent checks on the triple timer register port and interrupt pins
`timescale 1ns/1ps
`include "ttc_map.svh"

module ttc_properties
  import ttc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_sel,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ready,
  // interrupt
  input wire logic timer_irq,
  input wire logic [1:0] timer_irq_id,
  input wire logic timer_irq_ack
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wire take = reg_sel && (reg_rd || reg_wr) && !reg_ready;

  ////////////////////////////////////////////////////////////////
  sequence s_rd(logic [7:0] a);
    take && reg_rd && reg_addr == a;
  endsequence

  sequence s_answer;
    reg_ready ##1 !reg_ready;
  endsequence

  AST_READY_WAIT: assert property (take |=> s_answer)
    else $error("ready not one cycle after request");
  AST_READY_CAUSE: assert property (reg_ready |-> $past(take))
    else $error("ready without request");
  AST_IDLE_RDATA: assert property (!reg_ready |-> reg_rdata == 16'h0000)
    else $error("read data outside answer");
  AST_GATE_ZERO: assert property (s_rd(`TTC_OFS_T0_CONTROL) |=> !reg_rdata[`TTC_BIT_GATE])
    else $error("write gate bit read as one");
  AST_T2_RIU_ZERO: assert property (s_rd(`TTC_OFS_T2_CONTROL) |=> !reg_rdata[`TTC_BIT_RIU])
    else $error("timer 2 limit in use bit set");
  AST_IRQ_HOLD: assert property (timer_irq && !timer_irq_ack |=> timer_irq)
    else $error("request dropped without ack");
  AST_ID_RANGE: assert property (timer_irq |-> timer_irq_id != 2'h3)
    else $error("request id out of range");
  AST_TOP_PRIO: assert property (timer_irq && timer_irq_id == 2'h0 && !timer_irq_ack
    |=> timer_irq_id == 2'h0)
    else $error("top priority request displaced");
endmodule : ttc_properties

bind ttc_top ttc_properties u_props (.core_clk, .rst_n, .reg_sel, .reg_rd, .reg_wr,
  .reg_addr, .reg_rdata, .reg_ready, .timer_irq, .timer_irq_id, .timer_irq_ack);

/* File: verification/ttc_cpu_model.sv */
// processor side of the timer register port
`timescale 1ns/1ps

module ttc_cpu_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic reg_sel,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_ready
);
  initial
  begin
    reg_sel = 1'b0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end

  // holds the request until ready is sampled high or 8 clocks pass, then scrambles the idle bus
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
    input int gap);
    int n;
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    reg_sel <= 1'b1;
    reg_rd <= !wr;
    reg_wr <= wr;
    reg_addr <= a;
    reg_wdata <= d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (reg_ready !== 1'b1 && n < 8);
    reg_sel <= 1'b0;
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : access
endmodule : ttc_cpu_model

/* File: verification/tb_triple_timer_counter.sv */
// self-checking bench for the triple timer
`timescale 1ns/1ps
`include "ttc_map.svh"

module tb_triple_timer_counter;
  import ttc_pkg::*;
  typedef struct {ttc_word_t m; ttc_word_t x;} ttc_note_s;
  localparam ttc_word_t EN = 16'h0001 << `TTC_BIT_EN;
  localparam ttc_word_t GT = 16'h0001 << `TTC_BIT_GATE;
  localparam ttc_word_t IE = 16'h0001 << `TTC_BIT_IEN;
  localparam ttc_word_t MC = 16'h0001 << `TTC_BIT_MC;
  localparam ttc_word_t EX = 16'h0001 << `TTC_BIT_EXT;
  localparam ttc_word_t CT = 16'h0001 << `TTC_BIT_AUTO_REPEAT;
  localparam ttc_word_t RU = 16'h0001 << `TTC_BIT_RIU;
  localparam ttc_word_t RT = 16'h0001 << `TTC_BIT_RTG;
  localparam ttc_word_t PR = 16'h0001 << `TTC_BIT_PRE;
  localparam ttc_word_t AL = 16'h0001 << `TTC_BIT_ALT;
  // control bits that a write stores and a read returns
  localparam ttc_word_t CW = IE | MC | RT | PR | EX | AL | CT;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic in0 = 1'b0;
  logic in1 = 1'b0;
  logic ack = 1'b0;
  logic reg_sel, reg_rd, reg_wr, reg_ready, out0, out1, irq;
  logic [7:0] reg_addr;
  logic [1:0] irq_id;
  ttc_word_t reg_wdata, reg_rdata, d;
  ttc_note_s q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;

  always #12.5 core_clk = ~core_clk;

  ttc_top dut (.core_clk, .rst_n, .reg_sel, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_ready, .timer_in0(in0), .timer_in1(in1), .timer_out0(out0),
    .timer_out1(out1), .timer_irq(irq), .timer_irq_id(irq_id), .timer_irq_ack(ack));
  ttc_cpu_model cpu (.core_clk, .reg_sel, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_ready);

  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input ttc_word_t x, input ttc_word_t s);
    samples_checked++;
    if (s !== x)
    begin
      $display("[ERR] %s expected %h seen %h", nm, x, s);
      n_mismatch++;
    end
  endtask : check

  task wr(input logic [7:0] a, input ttc_word_t v);
    q.push_back('{16'h0000, 16'h0000});
    cpu.access(1'b1, a, v, $urandom_range(0, 2));
  endtask : wr

  task rd(input logic [7:0] a, input ttc_word_t m, input ttc_word_t x);
    q.push_back('{m, x});
    cpu.access(1'b0, a, 16'h0000, $urandom_range(0, 2));
  endtask : rd

  task results;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0 && q.size() == 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // every answer takes the oldest note
  always @(posedge core_clk)
  begin
    if (reg_ready === 1'b1 && q.size() > 0)
    begin
      if (q[0].m !== 16'h0000)
        check("reg_rdata", q[0].x, reg_rdata & q[0].m);
      void'(q.pop_front());
    end
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    results();
  end

  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(68308));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++)
      rd(`TTC_OFS_T0_CONTROL + 8'(8 * i), 16'hFFFF, 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      d = 16'($urandom);
      // control words keep the gate clear so no timer starts here
      if ((i % 4) == 3)
        d = d & ~GT;
      wr(`TTC_OFS_T0_COUNT + 8'(2 * i), d);
      rd(`TTC_OFS_T0_COUNT + 8'(2 * i), 16'hFFFF, ((i % 4) == 3) ? (d & CW) : d);
    end
    wr(`TTC_OFS_T0_COUNT, 16'h0000);
    wr(`TTC_OFS_T0_LIMIT_A, 16'h0000);
    wr(`TTC_OFS_T0_CONTROL, EN);
    rd(`TTC_OFS_T0_CONTROL, EN | GT, 16'h0000);
    wr(`TTC_OFS_T0_CONTROL, EN | GT);
    rd(`TTC_OFS_T0_CONTROL, EN | GT, EN);
    repeat (40) @(posedge core_clk);
    rd(`TTC_OFS_T0_COUNT, 16'hFFFF, 16'h0000);
    // retrigger mode holds the count until the first pin edge
    wr(`TTC_OFS_T0_CONTROL, EN | GT | RT);
    repeat (40) @(posedge core_clk);
    rd(`TTC_OFS_T0_COUNT, 16'hFFFF, 16'h0000);
    // dual limits: A then B, then the enable drops
    wr(`TTC_OFS_T0_CONTROL, GT);
    in0 <= 1'b1;
    wr(`TTC_OFS_T0_COUNT, 16'h0000);
    wr(`TTC_OFS_T0_LIMIT_A, 16'h0002);
    wr(`TTC_OFS_T0_LIMIT_B, 16'h0003);
    wr(`TTC_OFS_T0_CONTROL, EN | GT | AL);
    repeat (40) @(posedge core_clk);
    rd(`TTC_OFS_T0_CONTROL, EN | MC | RU | AL, MC | AL);
    rd(`TTC_OFS_T0_COUNT, 16'hFFFF, 16'h0000);
    check("timer_out0", 16'h0001, {15'h0000, out0});
    wr(`TTC_OFS_T0_CONTROL, GT);
    // timer 1 counts pin edges
    wr(`TTC_OFS_T1_COUNT, 16'h0000);
    wr(`TTC_OFS_T1_LIMIT_A, 16'h0000);
    wr(`TTC_OFS_T1_CONTROL, EN | GT | EX);
    n = $urandom_range(2, 6);
    repeat (n)
    begin
      @(posedge core_clk);
      in1 <= 1'b1;
      repeat (4) @(posedge core_clk);
      in1 <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (10) @(posedge core_clk);
    rd(`TTC_OFS_T1_COUNT, 16'hFFFF, 16'(n));
    // timer 2 single cycle with interrupt
    wr(`TTC_OFS_T2_COUNT, 16'h0000);
    wr(`TTC_OFS_T2_LIMIT_A, 16'h0003);
    wr(`TTC_OFS_T2_CONTROL, EN | GT | IE);
    n = 0;
    while (irq !== 1'b1 && n < 60)
    begin
      @(posedge core_clk);
      n++;
    end
    check("timer_irq_id", 16'h0002, {14'h0000, irq_id});
    rd(`TTC_OFS_T2_CONTROL, EN | MC, MC);
    rd(`TTC_OFS_T2_COUNT, 16'hFFFF, 16'h0000);
    @(posedge core_clk);
    ack <= 1'b1;
    @(posedge core_clk);
    ack <= 1'b0;
    @(posedge core_clk);
    #1 check("timer_irq", 16'h0000, {15'h0000, irq});
    rd(`TTC_OFS_T2_CONTROL, MC, MC);
    wr(`TTC_OFS_T2_CONTROL, GT);
    rd(`TTC_OFS_T2_CONTROL, 16'hFFFF, 16'h0000);
    // count above the limit wraps before it hits
    wr(`TTC_OFS_T2_COUNT, 16'hFFFE);
    wr(`TTC_OFS_T2_LIMIT_A, 16'h0002);
    wr(`TTC_OFS_T2_CONTROL, EN | GT | CT);
    repeat (4) @(posedge core_clk);
    rd(`TTC_OFS_T2_CONTROL, MC, 16'h0000);
    repeat (20) @(posedge core_clk);
    rd(`TTC_OFS_T2_CONTROL, MC | EN, MC | EN);
    wr(`TTC_OFS_T2_CONTROL, GT);
    // timer 1 steps on timer 2 timeouts only
    wr(`TTC_OFS_T1_CONTROL, EN | GT | PR);
    in1 <= 1'b1;
    wr(`TTC_OFS_T1_COUNT, 16'h0000);
    repeat (40) @(posedge core_clk);
    rd(`TTC_OFS_T1_COUNT, 16'hFFFF, 16'h0000);
    wr(`TTC_OFS_T2_COUNT, 16'h0000);
    wr(`TTC_OFS_T2_LIMIT_A, 16'h0002);
    wr(`TTC_OFS_T2_CONTROL, EN | GT);
    repeat (40) @(posedge core_clk);
    rd(`TTC_OFS_T1_COUNT, 16'hFFFF, 16'h0001);
    wr(`TTC_OFS_T1_CONTROL, GT);
    check("timer_out1", 16'h0001, {15'h0000, out1});
    // let the last answer reach the checker before the verdict
    repeat (2) @(posedge core_clk);
    results();
  end
endmodule : tb_triple_timer_counter
